// ==== core/stmon_channel.sv ====
// stmon_channel: overtemperature and measurement-error logic of one sensor.
// assumes readings and config come from logic on the same clock.
`timescale 1ns/10ps
module stmon_channel #(
	parameter int unsigned HOLD_TICKS = stmon_pkg::ERR_HOLD_MS
) (
	input  wire logic               clock,     // 20 MHz clock
	input  wire logic               nrst,      // synchronous reset, active low
	input  wire logic               msTick,    // one-cycle millisecond enable
	input  wire logic               resetReq,  // software fault reset pulse
	input  wire logic signed [15:0] temp,      // reading, tenths of a degree
	input  wire logic signed [15:0] setpoint,  // overtemperature threshold
	input  wire logic [1:0]         ovhAct,    // overtemperature action
	input  wire logic [1:0]         merrAct,   // measurement-error action
	output logic                    ovhFault,  // latched overtemperature fault
	output logic                    ovhAlarm,  // overtemperature alarm
	output logic                    merrFault, // measurement-error fault
	output logic                    merrAlarm  // measurement-error alarm
);
	logic [stmon_pkg::HOLD_W-1:0] lowCnt_q;
	logic ovhFault_q, ovhAlarm_q, merrLatch_q, merrFault_q, merrAlarm_q;
	wire overNow   = temp > setpoint;
	wire wantFault = (ovhAct == stmon_pkg::OVH_FAULT) || (ovhAct == stmon_pkg::OVH_BOTH);
	wire wantAlarm = (ovhAct == stmon_pkg::OVH_ALARM) || (ovhAct == stmon_pkg::OVH_BOTH);
	wire isLow     = temp <= stmon_pkg::ERR_LOW_LIM;
	wire expired   = lowCnt_q == stmon_pkg::HOLD_W'(HOLD_TICKS);
	wire clrOk     = temp > stmon_pkg::ERR_CLR_LIM;
	// detection sets win over a reset request in the same cycle
	wire ovhFault_d  = (overNow && wantFault) || (ovhFault_q && !(resetReq && !overNow));
	wire merrLatch_d = expired || (merrLatch_q && !(resetReq && clrOk));

	always_ff @(posedge clock) begin
		if (!nrst) begin
			lowCnt_q    <= '0;
			ovhFault_q  <= 1'b0;
			ovhAlarm_q  <= 1'b0;
			merrLatch_q <= 1'b0;
			merrFault_q <= 1'b0;
			merrAlarm_q <= 1'b0;
		end else begin
			if (!isLow)
				lowCnt_q <= '0;
			else if (msTick && !expired)
				lowCnt_q <= lowCnt_q + 1'b1;
			ovhFault_q  <= ovhFault_d;
			ovhAlarm_q  <= overNow && wantAlarm;
			merrLatch_q <= merrLatch_d;
			merrFault_q <= merrLatch_d && (merrAct == stmon_pkg::MERR_FAULT);
			merrAlarm_q <= merrLatch_d && (merrAct == stmon_pkg::MERR_ALARM);
		end
	end
	assign ovhFault  = ovhFault_q;
	assign ovhAlarm  = ovhAlarm_q;
	assign merrFault = merrFault_q;
	assign merrAlarm = merrAlarm_q;

	property p_ovh_fault_set;
		@(posedge clock) disable iff (!nrst) overNow && wantFault |=> ovhFault_q;
	endproperty
	a_ovh_fault_set: assert property (p_ovh_fault_set) else $error("overtemp fault not raised");
	property p_ovh_inactive;
		@(posedge clock) disable iff (!nrst) $past(ovhAct) == stmon_pkg::OVH_INACTIVE |-> !ovhAlarm_q;
	endproperty
	a_ovh_inactive: assert property (p_ovh_inactive) else $error("alarm while inactive");
	property p_merr_time;
		@(posedge clock) disable iff (!nrst) $rose(merrLatch_q) |-> $past(lowCnt_q) == HOLD_TICKS;
	endproperty
	a_merr_time: assert property (p_merr_time) else $error("measurement error too early");
	property p_merr_hold;
		@(posedge clock) disable iff (!nrst) merrLatch_q && !clrOk |=> merrLatch_q;
	endproperty
	a_merr_hold: assert property (p_merr_hold) else $error("error cleared while cold");
	property p_merr_off;
		@(posedge clock) disable iff (!nrst)
			$past(merrAct) == stmon_pkg::MERR_OFF |-> !merrFault_q && !merrAlarm_q;
	endproperty
	a_merr_off: assert property (p_merr_off) else $error("disabled error reported");
endmodule

// ==== core/stmon_top.sv ====
// stmon_top: slot temperature monitor with an AXI4-Lite register slave.
// assumes readings arrive from a converter on the same clock.
//
// Contract
// - kinds 0..3: platinum 100, 1000, PTC, triple PTC
// - one kind selection covers all sensors
// - overtemp action of sensor n at bits 2n-2..2n-1
// - actions: fault, alarm, both, neither
// - per-sensor setpoint, -100.0 to 250.0 degrees
// - cable break or short is measurement error
// - error action: fault, alarm, disabled, per sensor
// - error after five minutes at or below -20
// - error reset refused until above -15
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module stmon_top #(
	parameter int unsigned TICK_CYCLES = stmon_pkg::TICK_CYCLES,
	parameter int unsigned HOLD_TICKS  = stmon_pkg::ERR_HOLD_MS
) (
	input  wire logic        clock,        // 20 MHz clock
	input  wire logic        nrst,         // synchronous reset, active low
	input  wire logic [95:0] tempReadings, // six signed readings, sensor 1 low
	input  wire logic        motorRunning, // config writes refused while high
	output logic [1:0]       sensorKind,   // kind sent to the front end
	output logic             ptcMode,      // front end reads PTC sensors
	output logic             faultOut,     // any fault active
	output logic             alarmOut,     // any alarm active
	output logic             irq,          // level interrupt
	input  wire logic [7:0]  awaddr,       // write address
	input  wire logic        awvalid,      // write address valid
	output logic             awready,      // write address ready
	input  wire logic [31:0] wdata,        // write data
	input  wire logic [3:0]  wstrb,        // write byte lanes
	input  wire logic        wvalid,       // write data valid
	output logic             wready,       // write data ready
	output logic [1:0]       bresp,        // write response
	output logic             bvalid,       // write response valid
	input  wire logic        bready,       // write response ready
	input  wire logic [7:0]  araddr,       // read address
	input  wire logic        arvalid,      // read address valid
	output logic             arready,      // read address ready
	output logic [31:0]      rdata,        // read data
	output logic [1:0]       rresp,        // read response
	output logic             rvalid,       // read data valid
	input  wire logic        rready        // read data ready
);
	localparam int unsigned N = stmon_pkg::NSENS;

	function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction

	// out-of-range setpoints saturate rather than fault the bus
	function automatic logic signed [15:0] clampSp(input logic signed [15:0] v);
		if (v < stmon_pkg::SETPOINT_MIN)
			return stmon_pkg::SETPOINT_MIN;
		else if (v > stmon_pkg::SETPOINT_MAX)
			return stmon_pkg::SETPOINT_MAX;
		return v;
	endfunction

	logic [1:0]         kind_q;
	logic [11:0]        ovhCfg_q, merrCfg_q;
	logic signed [15:0] setpoint_q [N];
	logic [stmon_pkg::EVT_W-1:0] irqStat_q, irqEn_q, evtPrev_q;
	logic               resetReq_q;
	logic [stmon_pkg::TICK_W-1:0] tickCnt_q;
	logic               msTick_q;
	logic               awFull_q, wFull_q, bvalid_q, rvalid_q;
	logic [7:0]         awAddr_q;
	logic [31:0]        wData_q, rdata_q;
	logic [3:0]         wStrb_q;
	logic [1:0]         bresp_q, rresp_q;
	logic [N-1:0]       ovhFault, ovhAlarm, merrFault, merrAlarm;

	// millisecond enable for the cold-sensor timers
	always_ff @(posedge clock) begin
		if (!nrst) begin
			tickCnt_q <= '0;
			msTick_q  <= 1'b0;
		end else begin
			msTick_q  <= tickCnt_q == stmon_pkg::TICK_W'(TICK_CYCLES - 1);
			tickCnt_q <= (tickCnt_q == stmon_pkg::TICK_W'(TICK_CYCLES - 1)) ? '0 : tickCnt_q + 1'b1;
		end
	end

	for (genvar i = 0; i < N; i++) begin : g_ch
		stmon_channel #(.HOLD_TICKS(HOLD_TICKS)) u_ch (
			.clock     (clock),
			.nrst      (nrst),
			.msTick    (msTick_q),
			.resetReq  (resetReq_q),
			.temp      (tempReadings[stmon_pkg::TEMP_W*i +: stmon_pkg::TEMP_W]),
			.setpoint  (setpoint_q[i]),
			.ovhAct    (ovhCfg_q[2*i +: 2]),
			.merrAct   (merrCfg_q[2*i +: 2]),
			.ovhFault  (ovhFault[i]),
			.ovhAlarm  (ovhAlarm[i]),
			.merrFault (merrFault[i]),
			.merrAlarm (merrAlarm[i])
		);
	end

	// a single kind register drives the whole accessory
	assign sensorKind = kind_q;
	assign ptcMode    = (kind_q == stmon_pkg::KIND_SINGLE_PTC) || (kind_q == stmon_pkg::KIND_TRIPLE_PTC);
	assign faultOut   = |{ovhFault, merrFault};
	assign alarmOut   = |{ovhAlarm, merrAlarm};

	wire [stmon_pkg::EVT_W-1:0] evtNow  = {merrAlarm, merrFault, ovhAlarm, ovhFault};
	wire [stmon_pkg::EVT_W-1:0] evtRise = evtNow & ~evtPrev_q;
	assign irq = |(irqStat_q & irqEn_q);

	// write path: address and data are held apart until both have arrived
	assign awready = !awFull_q;
	assign wready  = !wFull_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	wire       doWrite = awFull_q && wFull_q && !bvalid_q;
	wire [7:0] wrAddr  = {awAddr_q[7:2], 2'b00};
	wire       wrKind  = wrAddr == stmon_pkg::OFF_KIND;
	wire       wrOvh   = wrAddr == stmon_pkg::OFF_OVH_CFG;
	wire       wrMerr  = wrAddr == stmon_pkg::OFF_MERR_CFG;
	wire [7:0] wrSpOff = wrAddr - stmon_pkg::OFF_SP0;
	wire       wrSp    = (wrAddr >= stmon_pkg::OFF_SP0) && (wrAddr < stmon_pkg::OFF_STATUS);
	wire [2:0] wrSpIdx = wrSpOff[4:2];
	wire       wrClr   = wrAddr == stmon_pkg::OFF_IRQ_CLR;
	wire       wrEn    = wrAddr == stmon_pkg::OFF_IRQ_EN;
	wire       wrCtrl  = wrAddr == stmon_pkg::OFF_CONTROL;
	wire       wrCfg   = wrKind || wrOvh || wrMerr || wrSp;
	wire       wrHit   = wrCfg || wrClr || wrEn || wrCtrl || wrAddr == stmon_pkg::OFF_STATUS
		|| wrAddr == stmon_pkg::OFF_IRQ_STAT;
	// configuration only changes with the motor stopped
	wire       cfgOk   = doWrite && wrCfg && !motorRunning;
	wire [31:0] wrMerged [4];
	assign wrMerged[0] = byteMerge({30'h0, kind_q}, wData_q, wStrb_q);
	assign wrMerged[1] = byteMerge({20'h0, ovhCfg_q}, wData_q, wStrb_q);
	assign wrMerged[2] = byteMerge({20'h0, merrCfg_q}, wData_q, wStrb_q);
	assign wrMerged[3] = byteMerge({{16{setpoint_q[wrSpIdx][15]}}, setpoint_q[wrSpIdx]}, wData_q, wStrb_q);
	wire [31:0] enMerged = byteMerge({8'h0, irqEn_q}, wData_q, wStrb_q);
	wire [stmon_pkg::EVT_W-1:0] clrMask = (doWrite && wrClr) ? wData_q[stmon_pkg::EVT_W-1:0] : '0;
	wire [1:0] wrResp  = !wrHit ? stmon_pkg::RESP_DECERR
		: (wrCfg && motorRunning) ? stmon_pkg::RESP_SLVERR : stmon_pkg::RESP_OKAY;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			awFull_q <= 1'b0;
			wFull_q  <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= stmon_pkg::RESP_OKAY;
			awAddr_q <= '0;
			wData_q  <= '0;
			wStrb_q  <= '0;
		end else begin
			if (awvalid && !awFull_q) begin
				awFull_q <= 1'b1;
				awAddr_q <= awaddr;
			end
			if (wvalid && !wFull_q) begin
				wFull_q <= 1'b1;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (doWrite) begin
				awFull_q <= 1'b0;
				wFull_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wrResp;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			kind_q     <= stmon_pkg::KIND_RST;
			ovhCfg_q   <= stmon_pkg::CFG_RST;
			merrCfg_q  <= stmon_pkg::CFG_RST;
			irqEn_q    <= '0;
			resetReq_q <= 1'b0;
			for (int i = 0; i < N; i++)
				setpoint_q[i] <= stmon_pkg::SETPOINT_RST;
		end else begin
			if (cfgOk && wrKind)
				kind_q <= wrMerged[0][1:0];
			if (cfgOk && wrOvh)
				ovhCfg_q <= wrMerged[1][11:0];
			if (cfgOk && wrMerr)
				merrCfg_q <= wrMerged[2][11:0];
			if (cfgOk && wrSp)
				setpoint_q[wrSpIdx] <= clampSp(wrMerged[3][15:0]);
			if (doWrite && wrEn)
				irqEn_q <= enMerged[stmon_pkg::EVT_W-1:0];
			resetReq_q <= doWrite && wrCtrl && wStrb_q[0] && wData_q[stmon_pkg::CTRL_RESET_BIT];
		end
	end

	// a new event wins over a clear in the same cycle
	always_ff @(posedge clock) begin
		if (!nrst) begin
			irqStat_q <= '0;
			evtPrev_q <= '0;
		end else begin
			evtPrev_q <= evtNow;
			irqStat_q <= evtRise | (irqStat_q & ~clrMask);
		end
	end

	// read path
	assign arready = !rvalid_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;
	wire [7:0] rdAddr  = {araddr[7:2], 2'b00};
	wire [7:0] rdSpOff = rdAddr - stmon_pkg::OFF_SP0;
	wire       rdSp    = (rdAddr >= stmon_pkg::OFF_SP0) && (rdAddr < stmon_pkg::OFF_STATUS);
	wire [2:0] rdSpIdx = rdSpOff[4:2];
	wire       rdZero  = (rdAddr == stmon_pkg::OFF_IRQ_CLR) || (rdAddr == stmon_pkg::OFF_CONTROL);
	wire [31:0] rdMux =
		(rdAddr == stmon_pkg::OFF_KIND)     ? {30'h0, kind_q} :
		(rdAddr == stmon_pkg::OFF_OVH_CFG)  ? {20'h0, ovhCfg_q} :
		(rdAddr == stmon_pkg::OFF_MERR_CFG) ? {20'h0, merrCfg_q} :
		rdSp                                ? {{16{setpoint_q[rdSpIdx][15]}}, setpoint_q[rdSpIdx]} :
		(rdAddr == stmon_pkg::OFF_STATUS)   ? {8'h0, evtNow} :
		(rdAddr == stmon_pkg::OFF_IRQ_STAT) ? {8'h0, irqStat_q} :
		(rdAddr == stmon_pkg::OFF_IRQ_EN)   ? {8'h0, irqEn_q} : 32'h0;
	wire rdHit = rdSp || rdZero || rdAddr <= stmon_pkg::OFF_MERR_CFG || rdAddr == stmon_pkg::OFF_STATUS
		|| rdAddr == stmon_pkg::OFF_IRQ_STAT || rdAddr == stmon_pkg::OFF_IRQ_EN;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= stmon_pkg::RESP_OKAY;
		end else if (arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rdMux;
			rresp_q  <= rdHit ? stmon_pkg::RESP_OKAY : stmon_pkg::RESP_DECERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end

	property p_kind_ptc;
		@(posedge clock) disable iff (!nrst)
			ptcMode == sensorKind[1];
	endproperty
	a_kind_ptc: assert property (p_kind_ptc) else $error("kind decode wrong");
	property p_kind_locked;
		@(posedge clock) disable iff (!nrst) motorRunning |=> $stable(kind_q) && $stable(ovhCfg_q);
	endproperty
	a_kind_locked: assert property (p_kind_locked) else $error("config changed while running");
	property p_sp_range;
		@(posedge clock) disable iff (!nrst)
			setpoint_q[1] >= stmon_pkg::SETPOINT_MIN && setpoint_q[1] <= stmon_pkg::SETPOINT_MAX;
	endproperty
	a_sp_range: assert property (p_sp_range) else $error("setpoint out of range");
	property p_field_s2;
		@(posedge clock) disable iff (!nrst)
			ovhCfg_q[3:2] == stmon_pkg::OVH_FAULT && $signed(tempReadings[31:16]) > setpoint_q[1] |=> ovhFault[1];
	endproperty
	a_field_s2: assert property (p_field_s2) else $error("sensor 2 field misplaced");
	// register writes land as sent, clamped only at the range ends
	property p_kind_write;
		@(posedge clock) disable iff (!nrst)
			cfgOk && wrKind && wStrb_q[0] |=> kind_q == $past(wData_q[1:0]);
	endproperty
	a_kind_write: assert property (p_kind_write) else $error("kind write lost");
	property p_ovh_write;
		@(posedge clock) disable iff (!nrst)
			cfgOk && wrOvh && (&wStrb_q[1:0]) |=> ovhCfg_q == $past(wData_q[11:0]);
	endproperty
	a_ovh_write: assert property (p_ovh_write) else $error("overtemp action write lost");
	property p_merr_write;
		@(posedge clock) disable iff (!nrst)
			cfgOk && wrMerr && (&wStrb_q[1:0]) |=> merrCfg_q == $past(wData_q[11:0]);
	endproperty
	a_merr_write: assert property (p_merr_write) else $error("error action write lost");
	property p_sp_clamp_hi;
		@(posedge clock) disable iff (!nrst)
			cfgOk && wrSp && wrSpIdx == 3'h0 && (&wStrb_q[1:0]) && $signed(wData_q[15:0]) > stmon_pkg::SETPOINT_MAX
			|=> setpoint_q[0] == stmon_pkg::SETPOINT_MAX;
	endproperty
	a_sp_clamp_hi: assert property (p_sp_clamp_hi) else $error("setpoint not clamped high");
	property p_sp_clamp_lo;
		@(posedge clock) disable iff (!nrst)
			cfgOk && wrSp && wrSpIdx == 3'h1 && (&wStrb_q[1:0]) && $signed(wData_q[15:0]) < stmon_pkg::SETPOINT_MIN
			|=> setpoint_q[1] == stmon_pkg::SETPOINT_MIN;
	endproperty
	a_sp_clamp_lo: assert property (p_sp_clamp_lo) else $error("setpoint not clamped low");
	property p_cfg_locked;
		@(posedge clock) disable iff (!nrst)
			motorRunning |=> $stable(merrCfg_q) && $stable(setpoint_q[0]) && $stable(setpoint_q[5]);
	endproperty
	a_cfg_locked: assert property (p_cfg_locked) else $error("setpoint changed while running");
	property p_reset_pulse;
		@(posedge clock) disable iff (!nrst) resetReq_q |-> $past(doWrite && wrCtrl);
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("stray fault reset pulse");
	property p_both_s3;
		@(posedge clock) disable iff (!nrst)
			ovhCfg_q[5:4] == stmon_pkg::OVH_BOTH && $signed(tempReadings[47:32]) > setpoint_q[2]
			|=> ovhAlarm[2] && ovhFault[2];
	endproperty
	a_both_s3: assert property (p_both_s3) else $error("sensor 3 both action missing");
endmodule

// ==== inc/stmon_pkg.sv ====
// stmon_pkg: constants shared by the slot temperature monitor.
// assumes a 20 MHz clock and readings in signed tenths of a degree C.
package stmon_pkg;
	localparam int unsigned CLOCK_HZ      = 20_000_000;
	localparam int unsigned TICK_HZ       = 1_000;
	localparam int unsigned TICK_CYCLES   = CLOCK_HZ / TICK_HZ;
	localparam int unsigned ERR_HOLD_MIN  = 5;
	localparam int unsigned ERR_HOLD_MS   = ERR_HOLD_MIN * 60 * TICK_HZ;
	localparam int unsigned TICK_W        = 16;
	localparam int unsigned HOLD_W        = 20;
	localparam int unsigned NSENS         = 6;
	localparam int unsigned TEMP_W        = 16;
	localparam int unsigned ADDR_W        = 8;

	localparam logic signed [15:0] SETPOINT_MIN = -16'sd1000;
	localparam logic signed [15:0] SETPOINT_MAX = 16'sd2500;
	localparam logic signed [15:0] SETPOINT_RST = 16'sd0;
	localparam logic signed [15:0] ERR_LOW_LIM  = -16'sd200;
	localparam logic signed [15:0] ERR_CLR_LIM  = -16'sd150;

	typedef enum logic [1:0] {KIND_PLATINUM_100_OHM, KIND_PLATINUM_1000_OHM,
		KIND_SINGLE_PTC, KIND_TRIPLE_PTC} stmon_kind_e;
	localparam logic [1:0] OVH_FAULT    = 2'h0;
	localparam logic [1:0] OVH_ALARM    = 2'h1;
	localparam logic [1:0] OVH_BOTH     = 2'h2;
	localparam logic [1:0] OVH_INACTIVE = 2'h3;
	localparam logic [1:0] MERR_FAULT   = 2'h0;
	localparam logic [1:0] MERR_ALARM   = 2'h1;
	localparam logic [1:0] MERR_OFF     = 2'h2;

	localparam logic [7:0] OFF_KIND     = 8'h00;
	localparam logic [7:0] OFF_OVH_CFG  = 8'h04;
	localparam logic [7:0] OFF_MERR_CFG = 8'h08;
	localparam logic [7:0] OFF_SP0      = 8'h0c;
	localparam logic [7:0] OFF_STATUS   = 8'h24;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h28;
	localparam logic [7:0] OFF_IRQ_CLR  = 8'h2c;
	localparam logic [7:0] OFF_IRQ_EN   = 8'h30;
	localparam logic [7:0] OFF_CONTROL  = 8'h34;
	localparam int unsigned CTRL_RESET_BIT = 0;
	localparam int unsigned EVT_W   = 4 * NSENS;
	localparam logic [1:0] KIND_RST = 2'h0;
	localparam logic [11:0] CFG_RST = 12'h000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ==== testbench/stmon_sensor_model.sv ====
// stmon_sensor_model: six-input temperature accessory behind the monitor.
// assumes the bench sets target temperatures and cable breaks on the monitor clock.
`timescale 1ns/10ps
module stmon_sensor_model #(
	parameter int unsigned LAT = 2
) (
	input  wire logic        clock,       // monitor clock
	input  wire logic [95:0] target,      // temperatures to report, sensor 1 low
	input  wire logic [5:0]  cableBroken, // per-sensor open cable
	output logic [95:0]      tempReadings // converted readings
);
	logic [95:0] pipe[LAT];
	logic [95:0] faulted;

	always_comb begin
		faulted = target;
		for (int i = 0; i < 6; i++) begin
			// an open cable reads far below any real temperature
			if (cableBroken[i]) begin
				faulted[16*i +: 16] = 16'hf830;
			end
		end
	end

	// conversion latency, so the monitor never sees a reading at once
	always_ff @(posedge clock) begin
		pipe[0] <= faulted;
		for (int i = 1; i < LAT; i++) begin
			pipe[i] <= pipe[i-1];
		end
	end

	assign tempReadings = pipe[LAT-1];
endmodule

// ==== testbench/test_slot_temperature_monitor.sv ====
// test_slot_temperature_monitor: self-checking bench for the slot temperature monitor.
// assumes short tick and hold counts so the long error wait fits the run.
`timescale 1ns/10ps
module test_slot_temperature_monitor;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] wd;
		logic [1:0]  bExp;
		logic [31:0] rExp;
		logic [1:0]  rrExp;
	} stmon_row_s;
	// kind, both action words, setpoints clamped high, clamped low and in range, read-only, write-only, unmapped
	localparam stmon_row_s ROWS[14] = '{
		'{8'h00, 32'h0, 2'h0, 32'h0, 2'h0}, '{8'h00, 32'h1, 2'h0, 32'h1, 2'h0},
		'{8'h00, 32'hfffffffe, 2'h0, 32'h2, 2'h0}, '{8'h00, 32'h3, 2'h0, 32'h3, 2'h0},
		'{8'h04, 32'habc, 2'h0, 32'habc, 2'h0}, '{8'h04, 32'hffffffff, 2'h0, 32'hfff, 2'h0},
		'{8'h08, 32'h555, 2'h0, 32'h555, 2'h0}, '{8'h0c, 32'hbb8, 2'h0, 32'h9c4, 2'h0},
		'{8'h10, 32'hfffff830, 2'h0, 32'hfffffc18, 2'h0}, '{8'h14, 32'h4d2, 2'h0, 32'h4d2, 2'h0},
		'{8'h20, 32'hfffffc18, 2'h0, 32'hfffffc18, 2'h0}, '{8'h24, 32'hffffff, 2'h0, 32'h0, 2'h0},
		'{8'h2c, 32'h0, 2'h0, 32'h0, 2'h0}, '{8'h40, 32'h5, 2'h3, 32'h0, 2'h3}};

	logic        clock, nrst, motorRunning, ptcMode, faultOut, alarmOut, irq;
	logic [95:0] target, tempReadings;
	logic [5:0]  cableBroken;
	logic [1:0]  sensorKind, bresp, rresp, rs;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0]  wstrb;
	int          errorCnt, numChecks;

	stmon_sensor_model #(.LAT(2)) partner (.clock(clock), .target(target), .cableBroken(cableBroken),
		.tempReadings(tempReadings));

	stmon_top #(.TICK_CYCLES(4), .HOLD_TICKS(10)) dut (.clock(clock), .nrst(nrst),
		.tempReadings(tempReadings), .motorRunning(motorRunning), .sensorKind(sensorKind),
		.ptcMode(ptcMode), .faultOut(faultOut), .alarmOut(alarmOut), .irq(irq), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic closeOut();
		$display("checks %0d mismatches %0d", numChecks, errorCnt);
		if (errorCnt == 0 && numChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// entered just after a rising edge; handshakes sampled at the falling edge, where all is settled
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
		logic aw, w, ar, done;
		{aw, w, ar, done} = 4'h0;
		if (wr) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		for (int n = 0; n < 40 && !done; n++) begin
			@(negedge clock);
			aw = awvalid & awready;
			w = wvalid & wready;
			ar = arvalid & arready;
			done = wr ? bvalid : rvalid;
			rs = wr ? bresp : rresp;
			rd = rdata;
			@(posedge clock);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (ar) arvalid <= 1'b0;
		end
		bready <= 1'b0;
		rready <= 1'b0;
		@(posedge clock);
		if (!done) begin
			errorCnt++;
			$display("[FAIL] bus answer expected 1 seen 0");
			closeOut();
		end
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		axi(1'b0, a, 32'h0);
		check($sformatf("reg %h", a), rd, exp);
	endtask

	initial begin
		{nrst, motorRunning, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
		{awaddr, araddr, wdata, cableBroken, errorCnt, numChecks} = '0;
		target = 96'h0;
		wstrb = 4'hf;
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		for (int i = 0; i < 14; i++) begin
			axi(1'b1, ROWS[i].a, ROWS[i].wd);
			check("bresp", 32'(rs), 32'(ROWS[i].bExp));
			rdChk(ROWS[i].a, ROWS[i].rExp);
			check("rresp", 32'(rs), 32'(ROWS[i].rrExp));
			if (ROWS[i].a == 8'h00) begin
				check("sensorKind", 32'(sensorKind), 32'(ROWS[i].rExp[1:0]));
				check("ptcMode", 32'(ptcMode), 32'(ROWS[i].rExp[1]));
			end
		end
		$display("register table done");
		nrst <= 1'b0;
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		rdChk(stmon_pkg::OFF_KIND, 32'h0);
		rdChk(stmon_pkg::OFF_OVH_CFG, 32'h0);
		rdChk(stmon_pkg::OFF_MERR_CFG, 32'h0);
		rdChk(stmon_pkg::OFF_SP0, 32'h0);
		$display("reset test done");
		// sensors 1..4 take action codes 0..3, all above a zero setpoint
		axi(1'b1, stmon_pkg::OFF_MERR_CFG, 32'haaa);
		axi(1'b1, stmon_pkg::OFF_OVH_CFG, 32'hfe4);
		target <= {32'h0, {4{16'h0064}}};
		repeat (6) @(posedge clock);
		rdChk(stmon_pkg::OFF_STATUS, 32'h185);
		check("faultOut", 32'(faultOut), 32'h1);
		axi(1'b1, stmon_pkg::OFF_CONTROL, 32'h1);
		rdChk(stmon_pkg::OFF_STATUS, 32'h185);
		target <= 96'h0;
		repeat (6) @(posedge clock);
		rdChk(stmon_pkg::OFF_STATUS, 32'h5);
		check("alarmOut", 32'(alarmOut), 32'h0);
		axi(1'b1, stmon_pkg::OFF_CONTROL, 32'h1);
		rdChk(stmon_pkg::OFF_STATUS, 32'h0);
		$display("overtemperature test done");
		// sensors 1..3 report fault, alarm, fault; sensor 4 is low but disabled
		axi(1'b1, stmon_pkg::OFF_OVH_CFG, 32'hfff);
		axi(1'b1, stmon_pkg::OFF_MERR_CFG, 32'ha84);
		target <= {32'h0, 16'hfed4, 16'h0, 16'hff38, 16'hff38};
		cableBroken <= 6'h04;
		repeat (30) @(posedge clock);
		rdChk(stmon_pkg::OFF_STATUS, 32'h0);
		repeat (30) @(posedge clock);
		rdChk(stmon_pkg::OFF_STATUS, 32'h85000);
		target <= {32'h0, 16'hfed4, 16'h0, 16'hff6a, 16'hff6a};
		cableBroken <= 6'h0;
		repeat (4) @(posedge clock);
		axi(1'b1, stmon_pkg::OFF_CONTROL, 32'h1);
		rdChk(stmon_pkg::OFF_STATUS, 32'h81000);
		check("faultOut", 32'(faultOut), 32'h1);
		check("alarmOut", 32'(alarmOut), 32'h1);
		target <= {32'h0, 16'hfed4, 16'h0, 16'hff6b, 16'hff6b};
		repeat (4) @(posedge clock);
		axi(1'b1, stmon_pkg::OFF_CONTROL, 32'h1);
		rdChk(stmon_pkg::OFF_STATUS, 32'h0);
		$display("measurement error test done");
		check("irq", 32'(irq), 32'h0);
		rdChk(stmon_pkg::OFF_IRQ_STAT, 32'h85185);
		axi(1'b1, stmon_pkg::OFF_IRQ_EN, 32'h1000);
		check("irq", 32'(irq), 32'h1);
		rdChk(stmon_pkg::OFF_IRQ_EN, 32'h1000);
		axi(1'b1, stmon_pkg::OFF_IRQ_CLR, 32'h1000);
		check("irq", 32'(irq), 32'h0);
		rdChk(stmon_pkg::OFF_IRQ_STAT, 32'h84185);
		// one byte lane only: the upper enable bytes must survive
		wstrb <= 4'h1;
		axi(1'b1, stmon_pkg::OFF_IRQ_EN, 32'hffffff05);
		wstrb <= 4'hf;
		rdChk(stmon_pkg::OFF_IRQ_EN, 32'h1005);
		check("irq", 32'(irq), 32'h1);
		axi(1'b1, stmon_pkg::OFF_IRQ_CLR, 32'hffffff);
		check("irq", 32'(irq), 32'h0);
		rdChk(stmon_pkg::OFF_IRQ_STAT, 32'h0);
		$display("interrupt test done");
		motorRunning <= 1'b1;
		axi(1'b1, stmon_pkg::OFF_KIND, 32'h3);
		check("bresp", 32'(rs), 32'(stmon_pkg::RESP_SLVERR));
		rdChk(stmon_pkg::OFF_KIND, 32'h0);
		motorRunning <= 1'b0;
		$display("running write test done");
		closeOut();
	end
endmodule
